//--- dv/cpu_instruction_subset_exec_tb_top.sv
// self-checking bench for the instruction subset executor
`timescale 1ns/1ps
module cpu_instruction_subset_exec_tb_top;
  logic                   clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic                   pready, pslverr, busy;
  logic [11:0]            paddr = 12'h0;
  logic [31:0]            pwdata = 32'h0, prdata, q;
  cpu_subset_pkg::flags_t flags;
  int                     mismatches = 0, n_tests = 0;
  always #2 clock = ~clock;
  cpu_subset_exec u_dut (.clock(clock), .rst_n(rst_n), .ce(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy), .flags(flags));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until pready is sampled high; a missing answer ends the run
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask
  function automatic logic [11:0] wAddr(input logic [3:0] n);
    return cpu_subset_pkg::WORK_BASE + {6'h0, n, 2'b00};
  endfunction
  task automatic setw(input logic [3:0] n, input logic [15:0] d);
    apb(1'b1, wAddr(n), {16'h0, d});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // four edges cover the busy window plus the result settling cycle
  task automatic run(input cpu_subset_pkg::op_t op, input logic [3:0] a, b, d, input logic [15:0] arg,
                     input logic [31:0] res, input logic [4:0] f);
    apb(1'b1, cpu_subset_pkg::ARG_OFF, {16'h0, arg});
    apb(1'b1, cpu_subset_pkg::CMD_OFF, {14'h0, op, a, b, d});
    repeat (4) @(posedge clock);
    rd(wAddr(d), res);
    chk({27'h0, flags}, {27'h0, f});
  endtask
  task automatic t_arith();
    apb(1'b1, cpu_subset_pkg::STAT_OFF, 32'h0); setw(4'h1, 16'h7fff);
    run(cpu_subset_pkg::OP_INC_W, 4'h1, 4'h0, 4'h2, 16'h0, 32'h8000, 5'h0e);
    setw(4'h1, 16'hfffe);
    run(cpu_subset_pkg::OP_ADD_TWO_OP_W, 4'h1, 4'h0, 4'h3, 16'h0, 32'h0, 5'h19);
    setw(4'h1, 16'h0001);
    run(cpu_subset_pkg::OP_NEG_W, 4'h1, 4'h0, 4'h8, 16'h0, 32'hffff, 5'h04);
    run(cpu_subset_pkg::OP_MOV_L16, 4'h0, 4'h0, 4'h9, 16'ha5c3, 32'ha5c3, 5'h04);
  endtask
  task automatic t_ior_mul();
    apb(1'b1, cpu_subset_pkg::STAT_OFF, 32'h1f); setw(4'h1, 16'h00f0); setw(4'h2, 16'h0f00);
    run(cpu_subset_pkg::OP_IOR_WW, 4'h1, 4'h2, 4'h4, 16'h0, 32'h0ff0, 5'h1a);
    setw(4'h1, 16'hffff); setw(4'h2, 16'hffff);
    run(cpu_subset_pkg::OP_MUL_UU, 4'h1, 4'h2, 4'h4, 16'h0, 32'h0001, 5'h1a);
    rd(wAddr(4'h5), 32'hfffe);
    run(cpu_subset_pkg::OP_MUL_SS, 4'h1, 4'h2, 4'h6, 16'h0, 32'h0001, 5'h1a);
    rd(wAddr(4'h7), 32'h0);
  endtask
  task automatic t_jump();
    apb(1'b1, cpu_subset_pkg::STAT_OFF, 32'h0a);
    run(cpu_subset_pkg::OP_JMP_ABS, 4'h0, 4'h0, 4'h0, 16'h0124, 32'h0, 5'h0a);
    rd(cpu_subset_pkg::PC_OFF, 32'h0124);
    rd(cpu_subset_pkg::STAT_OFF, 32'h280a);
    setw(4'h5, 16'h0200);
    run(cpu_subset_pkg::OP_JMP_IND, 4'h5, 4'h0, 4'h0, 16'h0, 32'h0, 5'h0a);
    rd(cpu_subset_pkg::PC_OFF, 32'h0200);
    rd(cpu_subset_pkg::STAT_OFF, 32'h240a);
  endtask
  // stack word at reset pointer 0x40 is data word 32, byte offset 0x180
  task automatic t_misc();
    apb(1'b1, cpu_subset_pkg::STAT_OFF, 32'h0); setw(4'h1, 16'h8001);
    run(cpu_subset_pkg::OP_LSR_W, 4'h1, 4'h0, 4'ha, 16'h0, 32'h4000, 5'h10);
    run(cpu_subset_pkg::OP_LSRM_L5, 4'h1, 4'h0, 4'hb, 16'h000f, 32'h0001, 5'h10);
    run(cpu_subset_pkg::OP_NOP, 4'h0, 4'h0, 4'hb, 16'h0, 32'h0001, 5'h10);
    run(cpu_subset_pkg::OP_MUL_UUL, 4'h1, 4'h0, 4'hc, 16'h0003, 32'h8003, 5'h10);
    rd(wAddr(4'hd), 32'h0001);
    run(cpu_subset_pkg::OP_PUSH_W, 4'h1, 4'h0, 4'hf, 16'h0, 32'h0042, 5'h10);
    rd(12'h180, 32'h8001);
    run(cpu_subset_pkg::OP_POP_W, 4'h0, 4'h0, 4'hd, 16'h0, 32'h8001, 5'h10);
    rd(wAddr(4'hf), 32'h0040);
    setw(4'h0, 16'h0002);
    run(cpu_subset_pkg::OP_MUL_F, 4'h0, 4'h0, 4'h2, 16'h0040, 32'h0002, 5'h10);
    rd(wAddr(4'h3), 32'h0001);
  endtask
  task automatic t_refuse();
    apb(1'b0, 12'h0f0, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, cpu_subset_pkg::CMD_OFF, 32'h3f000);
    chk({31'h0, e}, 32'h1);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_arith(); t_ior_mul(); t_jump(); t_misc(); t_refuse();
    wrap_up();
  end
endmodule
bind cpu_subset_exec cpu_subset_exec_properties u_chk (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy), .flags(flags));

//--- dv/cpu_subset_exec_properties.sv
// port-level properties of the instruction subset executor
`timescale 1ns/1ps
module cpu_subset_exec_properties (
  input wire logic                   clock,
  input wire logic                   rst_n,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   busy,
  input wire cpu_subset_pkg::flags_t flags
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_rd_wait; psel && penable && !pwrite && !pready; endsequence
  property p_busy_max; busy ##1 busy |=> !busy; endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy over two cycles");
  property p_busy_src; $rose(busy) |-> $past(pready && pwrite); endproperty
  a_busy_src: assert property (p_busy_src) else $error("busy without command");
  // flags may only move after an operation or a status write
  property p_flag_src; $changed(flags) |-> $past(busy) || $past(busy, 2) || $past(busy, 3) || $past(pready && pwrite);
  endproperty
  a_flag_src: assert property (p_flag_src) else $error("flags moved while idle");
  property p_rdy_one; pready |=> !pready; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready longer than one cycle");
  property p_rdy_src; pready |-> $past(psel && penable); endproperty
  a_rdy_src: assert property (p_rdy_src) else $error("pready without access");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  property p_rd_ans; s_rd_wait |=> pready; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_wr_zero; pready && pwrite |-> prdata == 32'h0; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("read data on write");
endmodule

//--- src/cpu_subset_exec.sv
// instruction subset executor with an apb register port
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
module cpu_subset_exec #(
  parameter int MEM_DEPTH = 64
) (
  input  wire logic                                clock,
  input  wire logic                                rst_n,
  input  wire logic                                ce,
  input  wire logic [cpu_subset_pkg::ADDR_W-1:0]   paddr,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  output logic                                     busy,
  output cpu_subset_pkg::flags_t                   flags
);
  localparam int IW = $clog2(MEM_DEPTH);

  function automatic logic twoCyc(input cpu_subset_pkg::op_t o);
    return o inside {cpu_subset_pkg::OP_JMP_ABS, cpu_subset_pkg::OP_JMP_IND, cpu_subset_pkg::OP_MOVD_ST,
                     cpu_subset_pkg::OP_MOVD_LD, cpu_subset_pkg::OP_POP_D, cpu_subset_pkg::OP_PUSH_D};
  endfunction

  function automatic logic [IW-1:0] memIdx(input logic [15:0] a);
    return a[IW:1];
  endfunction

  // returns {flags, result} of x plus a small positive k
  function automatic logic [20:0] addK(input logic [15:0] x, input logic [15:0] k);
    logic [16:0]            s;
    logic [8:0]             h;
    cpu_subset_pkg::flags_t f;
    s    = {1'b0, x} + {1'b0, k};
    h    = {1'b0, x[7:0]} + {1'b0, k[7:0]};
    f.c  = s[16];
    f.dc = h[8];
    f.n  = s[15];
    f.ov = ~x[15] & s[15];
    f.z  = (s[15:0] == 16'h0000);
    return {f, s[15:0]};
  endfunction

  function automatic logic [31:0] mulP(input logic [15:0] a, input logic [15:0] b,
                                       input logic sa, input logic sb);
    logic signed [16:0] ea;
    logic signed [16:0] eb;
    logic signed [33:0] p;
    ea = {sa & a[15], a};
    eb = {sb & b[15], b};
    p  = ea * eb;
    return p[31:0];
  endfunction

  localparam int SHADOW_N_L = cpu_subset_pkg::SHADOW_N;
  logic                   rstMeta_q;
  logic                   rstSync_q;
  logic [15:0]            w_q [16];
  logic [15:0]            mem_q [MEM_DEPTH];
  logic [15:0]            sh_q [SHADOW_N_L];
  cpu_subset_pkg::flags_t shFlags_q;
  cpu_subset_pkg::flags_t flags_q;
  cpu_subset_pkg::flags_t flD;
  cpu_subset_pkg::cmd_t   cmd_q;
  cpu_subset_pkg::state_t st_q;
  logic [15:0]            arg_q;
  logic [15:0]            pc_q;
  logic [15:0]            pcD;
  logic [1:0]             words_q;
  logic [1:0]             cyc_q;
  logic                   busy_q;
  logic                   pready_q;
  logic                   pslverr_q;
  logic [31:0]            prdata_q;

  // register decode
  wire logic        aligned  = (paddr[1:0] == 2'b00);
  wire logic        isCmd    = aligned & (paddr == cpu_subset_pkg::CMD_OFF);
  wire logic        isArg    = aligned & (paddr == cpu_subset_pkg::ARG_OFF);
  wire logic        isStat   = aligned & (paddr == cpu_subset_pkg::STAT_OFF);
  wire logic        isPc     = aligned & (paddr == cpu_subset_pkg::PC_OFF);
  wire logic        isW      = aligned & (paddr[11:6] == cpu_subset_pkg::WORK_BASE[11:6]);
  wire logic [11:0] memOff   = paddr - cpu_subset_pkg::MEM_BASE;
  wire logic        isMem    = aligned & (paddr >= cpu_subset_pkg::MEM_BASE)
                               & (memOff[11:2] < 10'(MEM_DEPTH));
  wire logic        badOp    = pwdata[17:12] > 6'(cpu_subset_pkg::OP_PUSH_S);
  wire logic        hit      = isCmd | isArg | isStat | isPc | isW | isMem;
  wire logic        accErr   = ~hit | (isCmd & pwrite & badOp);
  wire logic        access   = psel & penable;
  // writes wait while an operation runs so software never races the datapath
  wire logic        rdy      = access & ~pready_q & (~pwrite | ~busy_q);
  wire logic        wrFire   = access & pwrite & pready_q & ~pslverr_q;
  wire logic        cmdFire  = wrFire & isCmd;
  wire logic        exEn     = (st_q != cpu_subset_pkg::ST_IDLE);
  wire logic        ph2      = (st_q == cpu_subset_pkg::ST_CYC2);
  wire logic        last     = ph2 | ~twoCyc(cmd_q.op);
  wire logic        busyD    = exEn ? ~last : cmdFire;

  wire cpu_subset_pkg::op_t op = cmd_q.op;
  wire logic [15:0] wA    = w_q[cmd_q.wa];
  wire logic [15:0] wA1   = w_q[cmd_q.wa + 4'h1];
  wire logic [15:0] wB    = w_q[cmd_q.wb];
  wire logic [15:0] wD    = w_q[cmd_q.wd];
  wire logic [15:0] w0    = w_q[cpu_subset_pkg::DEF_W];
  wire logic [15:0] w14   = w_q[cpu_subset_pkg::FRAME_W];
  wire logic [15:0] sp    = w_q[cpu_subset_pkg::STACK_W];
  wire logic [15:0] spDn  = sp - cpu_subset_pkg::WORD_BYTES;
  wire logic [15:0] spUp  = sp + cpu_subset_pkg::WORD_BYTES;
  wire logic [15:0] slit  = {{6{arg_q[9]}}, arg_q[9:0]};
  wire logic [15:0] lit5  = {11'h000, arg_q[4:0]};
  wire logic [15:0] phOff = ph2 ? cpu_subset_pkg::WORD_BYTES : 16'h0000;
  wire logic        popOp = op inside {cpu_subset_pkg::OP_POP_F, cpu_subset_pkg::OP_POP_W, cpu_subset_pkg::OP_POP_D};
  wire logic [15:0] memRa = (op == cpu_subset_pkg::OP_MOV_LD)  ? wA + slit  :
                            (op == cpu_subset_pkg::OP_MOVD_LD) ? wA + phOff :
                            popOp                              ? spDn       : arg_q;
  wire logic [15:0] memRd = mem_q[memIdx(memRa)];
  wire logic        fSrc  = op inside {cpu_subset_pkg::OP_INC_F, cpu_subset_pkg::OP_INC_FW, cpu_subset_pkg::OP_ADD_TWO_OP_F,
                                       cpu_subset_pkg::OP_ADD_TWO_OP_FW, cpu_subset_pkg::OP_NEG_F, cpu_subset_pkg::OP_NEG_FW,
                                       cpu_subset_pkg::OP_LSR_F, cpu_subset_pkg::OP_LSR_FW};
  wire logic        toMem = op inside {cpu_subset_pkg::OP_INC_F, cpu_subset_pkg::OP_ADD_TWO_OP_F, cpu_subset_pkg::OP_NEG_F,
                                       cpu_subset_pkg::OP_LSR_F, cpu_subset_pkg::OP_IOR_F};
  wire logic        toW0  = op inside {cpu_subset_pkg::OP_INC_FW, cpu_subset_pkg::OP_ADD_TWO_OP_FW, cpu_subset_pkg::OP_NEG_FW,
                                       cpu_subset_pkg::OP_LSR_FW, cpu_subset_pkg::OP_IOR_FW};
  wire logic [15:0] uSrc  = fSrc ? memRd : wA;

  logic [15:0]         res;
  logic                grp;
  logic [31:0]         prod;
  logic                mulOp;
  logic [3:0]          mulLo;
  cpu_subset_pkg::wwr_t exW0;
  cpu_subset_pkg::wwr_t exW1;
  logic                exMWe;
  logic [15:0]         exMWa;
  logic [15:0]         exMWd;
  logic                shSave;
  logic                shLoad;

  always_comb begin
    res    = 16'h0000;
    grp    = 1'b0;
    prod   = 32'h0;
    mulOp  = 1'b0;
    mulLo  = cmd_q.wd;
    exW0   = '0;
    exW1   = '0;
    exMWe  = 1'b0;
    exMWa  = arg_q;
    exMWd  = 16'h0000;
    shSave = 1'b0;
    shLoad = 1'b0;
    flD    = flags_q;
    pcD    = pc_q + cpu_subset_pkg::WORD_BYTES;
    unique case (op)
      cpu_subset_pkg::OP_JMP_ABS: pcD = arg_q;
      cpu_subset_pkg::OP_JMP_IND: pcD = wA;
      cpu_subset_pkg::OP_INC_F, cpu_subset_pkg::OP_INC_FW, cpu_subset_pkg::OP_INC_W: begin
        {flD, res} = addK(uSrc, cpu_subset_pkg::ONE_K);
        grp        = 1'b1;
      end
      cpu_subset_pkg::OP_ADD_TWO_OP_F, cpu_subset_pkg::OP_ADD_TWO_OP_FW, cpu_subset_pkg::OP_ADD_TWO_OP_W: begin
        {flD, res} = addK(uSrc, cpu_subset_pkg::TWO_K);
        grp        = 1'b1;
      end
      cpu_subset_pkg::OP_NEG_F, cpu_subset_pkg::OP_NEG_FW, cpu_subset_pkg::OP_NEG_W: begin
        {flD, res} = addK(~uSrc, cpu_subset_pkg::ONE_K);
        grp        = 1'b1;
      end
      cpu_subset_pkg::OP_IOR_F, cpu_subset_pkg::OP_IOR_FW, cpu_subset_pkg::OP_IOR_L10,
      cpu_subset_pkg::OP_IOR_WW, cpu_subset_pkg::OP_IOR_L5: begin
        unique case (op)
          cpu_subset_pkg::OP_IOR_L10: res = {6'h00, arg_q[9:0]} | wD;
          cpu_subset_pkg::OP_IOR_WW:  res = wA | wB;
          cpu_subset_pkg::OP_IOR_L5:  res = wA | lit5;
          default:                    res = memRd | w0;
        endcase
        flD.n = res[15];
        flD.z = (res == 16'h0000);
        grp   = 1'b1;
      end
      cpu_subset_pkg::OP_LSR_F, cpu_subset_pkg::OP_LSR_FW, cpu_subset_pkg::OP_LSR_W: begin
        res    = {1'b0, uSrc[15:1]};
        flD.c  = uSrc[0];
        flD.n  = 1'b0;
        flD.ov = 1'b0;
        flD.z  = (res == 16'h0000);
        grp    = 1'b1;
      end
      cpu_subset_pkg::OP_LSRM_W, cpu_subset_pkg::OP_LSRM_L5: begin
        res   = wA >> ((op == cpu_subset_pkg::OP_LSRM_W) ? wB[4:0] : arg_q[4:0]);
        flD.n = res[15];
        flD.z = (res == 16'h0000);
        exW0  = '{1'b1, cmd_q.wd, res};
      end
      cpu_subset_pkg::OP_LNK: begin
        exMWe = 1'b1;
        exMWa = sp;
        exMWd = w14;
        exW0  = '{1'b1, cpu_subset_pkg::FRAME_W, spUp};
        exW1  = '{1'b1, cpu_subset_pkg::STACK_W, spUp + {2'b00, arg_q[13:0]}};
      end
      cpu_subset_pkg::OP_MOV_FW:  exW0 = '{1'b1, cmd_q.wd, memRd};
      cpu_subset_pkg::OP_MOV_LD:  exW0 = '{1'b1, cmd_q.wd, memRd};
      cpu_subset_pkg::OP_MOV_FF, cpu_subset_pkg::OP_MOV_FWREG, cpu_subset_pkg::OP_MOV_WREGF: begin
        res   = (op == cpu_subset_pkg::OP_MOV_WREGF) ? w0 : memRd;
        flD.n = res[15];
        flD.z = (res == 16'h0000);
        if (op == cpu_subset_pkg::OP_MOV_FWREG) begin
          exW0 = '{1'b1, cpu_subset_pkg::DEF_W, res};
        end else begin
          exMWe = 1'b1;
          exMWd = res;
        end
      end
      cpu_subset_pkg::OP_MOV_L16: exW0 = '{1'b1, cmd_q.wd, arg_q};
      cpu_subset_pkg::OP_MOV_L8:  exW0 = '{1'b1, cmd_q.wd, {wD[15:8], arg_q[7:0]}};
      cpu_subset_pkg::OP_MOV_WF: begin
        exMWe = 1'b1;
        exMWd = wA;
      end
      cpu_subset_pkg::OP_MOV_ST: begin
        exMWe = 1'b1;
        exMWa = wD + slit;
        exMWd = wA;
      end
      cpu_subset_pkg::OP_MOV_WW:  exW0 = '{1'b1, cmd_q.wd, wA};
      cpu_subset_pkg::OP_MOVD_ST: begin
        exMWe = 1'b1;
        exMWa = wD + phOff;
        exMWd = ph2 ? wA1 : wA;
      end
      cpu_subset_pkg::OP_MOVD_LD: exW0 = '{1'b1, ph2 ? cmd_q.wd + 4'h1 : cmd_q.wd, memRd};
      cpu_subset_pkg::OP_MUL_SS:  begin prod = mulP(wA, wB, 1'b1, 1'b1); mulOp = 1'b1; end
      cpu_subset_pkg::OP_MUL_SU:  begin prod = mulP(wA, wB, 1'b1, 1'b0); mulOp = 1'b1; end
      cpu_subset_pkg::OP_MUL_US:  begin prod = mulP(wA, wB, 1'b0, 1'b1); mulOp = 1'b1; end
      cpu_subset_pkg::OP_MUL_UU:  begin prod = mulP(wA, wB, 1'b0, 1'b0); mulOp = 1'b1; end
      cpu_subset_pkg::OP_MUL_SUL: begin prod = mulP(wA, lit5, 1'b1, 1'b0); mulOp = 1'b1; end
      cpu_subset_pkg::OP_MUL_UUL: begin prod = mulP(wA, lit5, 1'b0, 1'b0); mulOp = 1'b1; end
      cpu_subset_pkg::OP_MUL_F: begin
        prod  = mulP(memRd, w0, 1'b0, 1'b0);
        mulOp = 1'b1;
        mulLo = cpu_subset_pkg::PROD_LO_W;
      end
      cpu_subset_pkg::OP_NOP, cpu_subset_pkg::OP_IDLE_ALT_OP: ;
      cpu_subset_pkg::OP_POP_F: begin
        exMWe = 1'b1;
        exMWd = memRd;
        exW1  = '{1'b1, cpu_subset_pkg::STACK_W, spDn};
      end
      cpu_subset_pkg::OP_POP_W, cpu_subset_pkg::OP_POP_D: begin
        exW0 = '{1'b1, (op == cpu_subset_pkg::OP_POP_D && !ph2) ? cmd_q.wd + 4'h1 : cmd_q.wd, memRd};
        exW1 = '{1'b1, cpu_subset_pkg::STACK_W, spDn};
      end
      cpu_subset_pkg::OP_POP_S: begin
        shLoad = 1'b1;
        flD    = shFlags_q;
      end
      cpu_subset_pkg::OP_PUSH_F, cpu_subset_pkg::OP_PUSH_W, cpu_subset_pkg::OP_PUSH_D: begin
        exMWe = 1'b1;
        exMWa = sp;
        exMWd = (op == cpu_subset_pkg::OP_PUSH_F) ? memRd : (ph2 ? wA1 : wA);
        exW1  = '{1'b1, cpu_subset_pkg::STACK_W, spUp};
      end
      cpu_subset_pkg::OP_PUSH_S: shSave = 1'b1;
      default: ;
    endcase
    if (grp) begin
      if (toMem) begin
        exMWe = 1'b1;
        exMWd = res;
      end else begin
        exW0 = '{1'b1, toW0 ? cpu_subset_pkg::DEF_W : cmd_q.wd, res};
      end
    end
    if (mulOp) begin
      exW0 = '{1'b1, mulLo, prod[15:0]};
      exW1 = '{1'b1, mulLo + 4'h1, prod[31:16]};
    end
  end

  // apb writes and the datapath never overlap, so one write port of each kind serves both
  wire cpu_subset_pkg::wwr_t wp0   = exEn ? exW0 : '{wrFire & isW, paddr[5:2], pwdata[15:0]};
  wire logic                 mWe   = exEn ? exMWe : (wrFire & isMem);
  wire logic [IW-1:0]        mWi   = exEn ? memIdx(exMWa) : memOff[IW+1:2];
  wire logic [15:0]          mWd   = exEn ? exMWd : pwdata[15:0];
  wire logic [31:0]          statW = {16'h0000, 2'b00, cyc_q, words_q, 1'b0, busy_q, 3'b000, flags_q};
  wire logic [31:0]          rdata = isCmd  ? 32'(cmd_q)              :
                                     isArg  ? {16'h0000, arg_q}       :
                                     isStat ? statW                   :
                                     isPc   ? {16'h0000, pc_q}        :
                                     isW    ? {16'h0000, w_q[paddr[5:2]]} :
                                     isMem  ? {16'h0000, mem_q[memOff[IW+1:2]]} : 32'h0;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else if (ce) begin
      pready_q  <= rdy;
      pslverr_q <= rdy & accErr;
      if (rdy) prdata_q <= pwrite ? 32'h0 : rdata;
    end
  end

  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      st_q    <= cpu_subset_pkg::ST_IDLE;
      busy_q  <= 1'b0;
      cmd_q   <= '{cpu_subset_pkg::OP_NOP, 4'h0, 4'h0, 4'h0};
      arg_q   <= 16'h0000;
      pc_q    <= cpu_subset_pkg::PC_RST;
      flags_q <= cpu_subset_pkg::FLAGS_RST;
      words_q <= 2'h0;
      cyc_q   <= 2'h0;
    end else if (ce) begin
      busy_q <= busyD;
      unique case (st_q)
        cpu_subset_pkg::ST_IDLE: if (cmdFire) st_q <= cpu_subset_pkg::ST_CYC1;
        cpu_subset_pkg::ST_CYC1: st_q <= last ? cpu_subset_pkg::ST_IDLE : cpu_subset_pkg::ST_CYC2;
        cpu_subset_pkg::ST_CYC2: st_q <= cpu_subset_pkg::ST_IDLE;
      endcase
      if (cmdFire) cmd_q <= cpu_subset_pkg::cmd_t'(pwdata[17:0]);
      if (wrFire & isArg) arg_q <= pwdata[15:0];
      if (wrFire & isPc) pc_q <= pwdata[15:0];
      if (wrFire & isStat) flags_q <= cpu_subset_pkg::flags_t'(pwdata[4:0]);
      if (exEn) flags_q <= flD;
      if (exEn & last) begin
        pc_q    <= pcD;
        words_q <= (op == cpu_subset_pkg::OP_JMP_ABS) ? cpu_subset_pkg::TWO_N : cpu_subset_pkg::ONE_N;
        cyc_q   <= ph2 ? cpu_subset_pkg::TWO_N : cpu_subset_pkg::ONE_N;
      end
    end
  end

  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      for (int i = 0; i < 16; i++) w_q[i] <= (i == 15) ? cpu_subset_pkg::SP_RST : cpu_subset_pkg::W_RST;
      for (int i = 0; i < SHADOW_N_L; i++) sh_q[i] <= cpu_subset_pkg::W_RST;
      shFlags_q <= cpu_subset_pkg::FLAGS_RST;
    end else if (ce) begin
      if (exEn & exW1.en) w_q[exW1.idx] <= exW1.val;
      if (wp0.en) w_q[wp0.idx] <= wp0.val;
      if (exEn & shSave) begin
        for (int i = 0; i < SHADOW_N_L; i++) sh_q[i] <= w_q[i];
        shFlags_q <= flags_q;
      end
      if (exEn & shLoad) begin
        for (int i = 0; i < SHADOW_N_L; i++) w_q[i] <= sh_q[i];
      end
    end
  end

  // data memory holds no control state, so it is left unreset
  always_ff @(posedge clock) begin
    if (ce & mWe) mem_q[mWi] <= mWd;
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign busy    = busy_q;
  assign flags   = flags_q;
endmodule

//--- src/cpu_subset_pkg.sv
// shared constants and types of the instruction subset executor
package cpu_subset_pkg;
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] CMD_OFF     = 12'h000;
  localparam logic [11:0] ARG_OFF     = 12'h004;
  localparam logic [11:0] STAT_OFF    = 12'h008;
  localparam logic [11:0] PC_OFF      = 12'h00c;
  localparam logic [11:0] WORK_BASE   = 12'h040;
  localparam logic [11:0] MEM_BASE    = 12'h100;
  localparam logic [3:0]  DEF_W       = 4'h0;
  localparam logic [3:0]  PROD_LO_W   = 4'h2;
  localparam logic [3:0]  PROD_HI_W   = 4'h3;
  localparam logic [3:0]  FRAME_W     = 4'he;
  localparam logic [3:0]  STACK_W     = 4'hf;
  localparam logic [15:0] PC_RST      = 16'h0000;
  localparam logic [15:0] SP_RST      = 16'h0040;
  localparam logic [15:0] W_RST       = 16'h0000;
  localparam logic [15:0] WORD_BYTES  = 16'h0002;
  localparam logic [15:0] ONE_K       = 16'h0001;
  localparam logic [15:0] TWO_K       = 16'h0002;
  localparam logic [1:0]  ONE_N       = 2'h1;
  localparam logic [1:0]  TWO_N       = 2'h2;
  localparam int          SHADOW_N    = 4;
  localparam int          STAT_BUSY   = 8;
  localparam int          STAT_WORDS  = 10;
  localparam int          STAT_CYC    = 12;

  typedef enum logic [5:0] {
    OP_JMP_ABS, OP_JMP_IND,
    OP_INC_F, OP_INC_FW, OP_INC_W, OP_ADD_TWO_OP_F, OP_ADD_TWO_OP_FW, OP_ADD_TWO_OP_W,
    OP_IOR_F, OP_IOR_FW, OP_IOR_L10, OP_IOR_WW, OP_IOR_L5,
    OP_LNK,
    OP_LSR_F, OP_LSR_FW, OP_LSR_W, OP_LSRM_W, OP_LSRM_L5,
    OP_MOV_FW, OP_MOV_LD, OP_MOV_FF, OP_MOV_FWREG, OP_MOV_L16, OP_MOV_L8,
    OP_MOV_WF, OP_MOV_ST, OP_MOV_WW, OP_MOV_WREGF, OP_MOVD_ST, OP_MOVD_LD,
    OP_MUL_SS, OP_MUL_SU, OP_MUL_US, OP_MUL_UU, OP_MUL_SUL, OP_MUL_UUL, OP_MUL_F,
    OP_NEG_F, OP_NEG_FW, OP_NEG_W,
    OP_NOP, OP_IDLE_ALT_OP,
    OP_POP_F, OP_POP_W, OP_POP_D, OP_POP_S,
    OP_PUSH_F, OP_PUSH_W, OP_PUSH_D, OP_PUSH_S
  } op_t;

  typedef struct packed {
    op_t        op;
    logic [3:0] wa;
    logic [3:0] wb;
    logic [3:0] wd;
  } cmd_t;

  typedef struct packed {
    logic c;
    logic dc;
    logic n;
    logic ov;
    logic z;
  } flags_t;

  typedef struct packed {
    logic        en;
    logic [3:0]  idx;
    logic [15:0] val;
  } wwr_t;

  typedef enum logic [1:0] {ST_IDLE, ST_CYC1, ST_CYC2} state_t;

  localparam flags_t FLAGS_RST = '0;
endpackage
